// >>> rtl/uswf_top.sv
// Software flow control, FIFO level counters and control character status for one UART channel.
//
// Operation
// - Upper select bits: none, first pair, second pair, or both characters in sequence.
// - Lower select bits: none, match first pair, or match second pair.
// - Lower 11 with one transmit pair: accept first or second character.
// - Lower 11 with upper 11 or 00: match only consecutive two-character sequences.
// - Select field is zero after reset, no in-band flow control.
// - Direction output goes transmit while data is queued or leaving, not for control characters alone.
// - Transmit level count reports FIFO fill; 0xff means 255 or 256.
// - Transmit interrupt while transmit fill is below transmit trigger.
// - Receive level count reports receive FIFO fill from 0x00 to 0xff.
// - Receive interrupt when receive fill reaches a nonzero receive trigger.
// - Four write-only stop and resume character registers.
// - Status reads zero whenever software flow control is disabled; upper nibble reserved.
// - Bit 3 set when last sent control was resume; clears on read.
// - Bit 2 set when last sent control was stop; clears on read.
// - Bit 1 set when last received control was resume; clears on read.
// - Bit 0 set when last received control was stop; clears on read.
// - Modem status delta bits clear at reset, upper bits follow inputs.
`timescale 1ns/1ps
module uswf_top (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       host_tx_push,
  input  wire logic [7:0] host_tx_data,
  input  wire logic       host_rx_pop,
  input  wire logic       rx_char_valid,
  input  wire logic [7:0] rx_char,
  input  wire logic [3:0] modem_in,
  input  wire logic       ser_ready,
  output logic            ser_valid,
  output logic      [7:0] ser_data,
  output logic            rx_fifo_push,
  output logic      [7:0] rx_fifo_data,
  output logic            tx_irq,
  output logic            rx_irq,
  output logic            dir_tx,
  output logic            tx_halted
);
  logic [7:0] enhanced_feature_control, fsel, tx_fifo_trigger_level, rx_fifo_trigger_level, stop1, stop2, res1, res2, xstat, msr_lo, scratchpad_reg;
  logic [7:0] next_efr, next_fsel, next_tx_fifo_trigger_level, next_rx_fifo_trigger_level, next_stop1, next_stop2;
  logic [7:0] next_res1, next_res2, next_xstat, next_msr_lo, next_spr, next_rdata;
  logic [8:0] txfill, rxfill, next_txfill, next_rxfill;
  logic       halted, next_halted, rx_stopped, next_rx_stopped;
  logic       pend_stop, next_pend_stop, pend_res, next_pend_res;
  logic       send_stop, next_send_stop, tx_busy, next_tx_busy;
  logic       rx_half, next_rx_half, rx_half_stop, next_rx_half_stop;
  logic       ser_valid_n, dir_n, rxp_n;
  logic [7:0] ser_data_n, rxd_n;
  uswf_pkg::uswf_tx_state_t st, next_st;
  logic [1:0] txsel, rxsel;
  logic       sw_on, rx_is_stop, rx_is_res, rx_half_hit, rx_half_res, ctl_done, data_pop;
  localparam int FSEL_HDX_BIT = uswf_pkg::FSEL_HDX_BIT;
  localparam int XS_TX_RES    = uswf_pkg::XS_TX_RES;
  localparam int XS_TX_STOP   = uswf_pkg::XS_TX_STOP;
  localparam int XS_RX_RES    = uswf_pkg::XS_RX_RES;
  localparam int XS_RX_STOP   = uswf_pkg::XS_RX_STOP;

  function automatic logic [7:0] uswf_level(input logic [8:0] fill);
    uswf_level = (fill >= uswf_pkg::FIFO_DEPTH) ? uswf_pkg::CNT_MAX : fill[7:0];
  endfunction : uswf_level

  assign txsel = enhanced_feature_control[3:2];
  assign rxsel = enhanced_feature_control[1:0];
  assign sw_on = (enhanced_feature_control[3:0] != 4'h0);

  // Receive matching; a two-character sequence keeps the first half pending.
  always_comb begin
    rx_is_stop       = 1'b0;
    rx_is_res        = 1'b0;
    rx_half_hit      = 1'b0;
    rx_half_res      = 1'b0;
    case (rxsel)
      uswf_pkg::SEL_FIRST: begin
        rx_is_stop = (rx_char == stop1);
        rx_is_res  = (rx_char == res1);
      end
      uswf_pkg::SEL_SECOND: begin
        rx_is_stop = (rx_char == stop2);
        rx_is_res  = (rx_char == res2);
      end
      uswf_pkg::SEL_BOTH: begin
        if (txsel == uswf_pkg::SEL_FIRST || txsel == uswf_pkg::SEL_SECOND) begin
          rx_is_stop = (rx_char == stop1) || (rx_char == stop2);
          rx_is_res  = (rx_char == res1) || (rx_char == res2);
        end else begin
          rx_is_stop  = rx_half && rx_half_stop && (rx_char == stop2);
          rx_is_res   = rx_half && !rx_half_stop && (rx_char == res2);
          rx_half_hit = (rx_char == stop1) || (rx_char == res1);
          rx_half_res = (rx_char == res1);
        end
      end
      default: begin
        rx_is_stop = 1'b0;
      end
    endcase
  end

  // Flow control characters are consumed; all others go to the receive FIFO.
  always_comb begin
    next_rx_half      = rx_half;
    next_rx_half_stop = rx_half_stop;
    next_halted       = halted;
    rxp_n             = 1'b0;
    rxd_n             = rx_char;
    if (!sw_on) begin
      next_rx_half = 1'b0;
      next_halted  = 1'b0;
    end
    if (rx_char_valid) begin
      next_rx_half = 1'b0;
      if (rx_is_stop) begin
        next_halted = 1'b1;
      end else if (rx_is_res) begin
        next_halted = 1'b0;
      end else if (rx_half_hit) begin
        next_rx_half      = 1'b1;
        next_rx_half_stop = !rx_half_res;
      end else begin
        rxp_n = 1'b1;
      end
    end
  end

  assign data_pop = (st == uswf_pkg::USWF_TX_DATA) && ser_ready;
  assign ctl_done = (st == uswf_pkg::USWF_TX_C2 || (st == uswf_pkg::USWF_TX_C1 && txsel != uswf_pkg::SEL_BOTH))
                    && ser_valid && ser_ready;

  // Transmit sequencer: control characters take priority over data.
  always_comb begin
    next_st         = st;
    next_send_stop  = send_stop;
    next_pend_stop  = pend_stop;
    next_pend_res   = pend_res;
    next_rx_stopped = rx_stopped;
    next_tx_busy    = tx_busy;
    ser_valid_n     = 1'b0;
    ser_data_n      = ser_data;
    dir_n           = dir_tx;
    if (txsel == uswf_pkg::SEL_NONE) begin
      next_pend_stop  = 1'b0;
      next_pend_res   = 1'b0;
      next_rx_stopped = 1'b0;
    end else if (!rx_stopped && rxfill >= {1'b0, rx_fifo_trigger_level}) begin
      next_rx_stopped = 1'b1;
      next_pend_stop  = 1'b1;
      next_pend_res   = 1'b0;
    end else if (rx_stopped && rxfill < {1'b0, rx_fifo_trigger_level}) begin
      next_rx_stopped = 1'b0;
      next_pend_res   = 1'b1;
      next_pend_stop  = 1'b0;
    end
    case (st)
      uswf_pkg::USWF_TX_IDLE: begin
        if (pend_stop || pend_res) begin
          next_st        = uswf_pkg::USWF_TX_C1;
          next_send_stop = pend_stop;
          next_pend_stop = 1'b0;
          next_pend_res  = 1'b0;
        end else if (txfill != 9'h000 && !halted) begin
          next_st = uswf_pkg::USWF_TX_DATA;
        end
      end
      uswf_pkg::USWF_TX_C1: begin
        if (ser_ready) begin
          next_st = (txsel == uswf_pkg::SEL_BOTH) ? uswf_pkg::USWF_TX_C2 : uswf_pkg::USWF_TX_IDLE;
        end
      end
      uswf_pkg::USWF_TX_C2: begin
        if (ser_valid && ser_ready) begin
          next_st = uswf_pkg::USWF_TX_IDLE;
        end
      end
      uswf_pkg::USWF_TX_DATA: begin
        if (ser_ready) begin
          next_st = uswf_pkg::USWF_TX_IDLE;
        end
      end
      default: begin
        next_st = uswf_pkg::USWF_TX_IDLE;
      end
    endcase
    case (next_st)
      uswf_pkg::USWF_TX_C1: begin
        ser_valid_n = 1'b1;
        if (txsel == uswf_pkg::SEL_SECOND) begin
          ser_data_n = next_send_stop ? stop2 : res2;
        end else begin
          ser_data_n = next_send_stop ? stop1 : res1;
        end
      end
      uswf_pkg::USWF_TX_C2: begin
        // The second character waits one cycle, so valid always drops after an accepted character.
        ser_valid_n = (st == uswf_pkg::USWF_TX_C2);
        ser_data_n  = send_stop ? stop2 : res2;
      end
      uswf_pkg::USWF_TX_DATA: begin
        ser_valid_n = 1'b1;
        ser_data_n  = host_tx_data;
      end
      default: begin
        ser_valid_n = 1'b0;
      end
    endcase
    // Data in flight or queued drives the direction; control characters alone never do.
    next_tx_busy = (next_st == uswf_pkg::USWF_TX_DATA);
    dir_n        = fsel[FSEL_HDX_BIT] && (next_tx_busy || txfill != 9'h000);
  end

  // Fill counters track the FIFOs that sit outside this block.
  always_comb begin
    next_txfill = txfill;
    next_rxfill = rxfill;
    if (host_tx_push && !data_pop && txfill < uswf_pkg::FIFO_DEPTH) begin
      next_txfill = txfill + 9'h001;
    end else if (data_pop && !host_tx_push && txfill != 9'h000) begin
      next_txfill = txfill - 9'h001;
    end
    if (rxp_n && !host_rx_pop && rxfill < uswf_pkg::FIFO_DEPTH) begin
      next_rxfill = rxfill + 9'h001;
    end else if (host_rx_pop && !rxp_n && rxfill != 9'h000) begin
      next_rxfill = rxfill - 9'h001;
    end
  end

  // Register file; status sets win over the clear-on-read.
  always_comb begin
    next_efr    = enhanced_feature_control;
    next_fsel   = fsel;
    next_tx_fifo_trigger_level  = tx_fifo_trigger_level;
    next_rx_fifo_trigger_level  = rx_fifo_trigger_level;
    next_stop1  = stop1;
    next_stop2  = stop2;
    next_res1   = res1;
    next_res2   = res2;
    next_spr    = scratchpad_reg;
    next_msr_lo = msr_lo;
    next_xstat  = xstat;
    next_rdata  = uswf_pkg::RST_ZERO;
    if (wr) begin
      case (addr)
        uswf_pkg::ADDR_EFR:   next_efr   = wdata;
        uswf_pkg::ADDR_FSEL:  next_fsel  = wdata;
        uswf_pkg::ADDR_TX_FIFO_TRIGGER_LEVEL: next_tx_fifo_trigger_level = wdata;
        uswf_pkg::ADDR_RX_FIFO_TRIGGER_LEVEL: next_rx_fifo_trigger_level = wdata;
        uswf_pkg::ADDR_STOP1: next_stop1 = wdata;
        uswf_pkg::ADDR_STOP2: next_stop2 = wdata;
        uswf_pkg::ADDR_RES1:  next_res1  = wdata;
        uswf_pkg::ADDR_RES2:  next_res2  = wdata;
        uswf_pkg::ADDR_SPR:   next_spr   = wdata;
        default:              next_spr   = scratchpad_reg;
      endcase
    end
    if (rd) begin
      case (addr)
        uswf_pkg::ADDR_EFR:   next_rdata = enhanced_feature_control;
        uswf_pkg::ADDR_FSEL:  next_rdata = fsel;
        uswf_pkg::ADDR_TX_FIFO_LEVEL_COUNT: next_rdata = uswf_level(txfill);
        uswf_pkg::ADDR_RX_FIFO_LEVEL_COUNT: next_rdata = uswf_level(rxfill);
        uswf_pkg::ADDR_XSTAT: next_rdata = {4'h0, xstat[3:0]};
        uswf_pkg::ADDR_MSR:   next_rdata = {modem_in, msr_lo[3:0]};
        uswf_pkg::ADDR_SPR:   next_rdata = scratchpad_reg;
        uswf_pkg::ADDR_LSR:   next_rdata = uswf_pkg::RST_LSR;
        uswf_pkg::ADDR_ISR:   next_rdata = uswf_pkg::RST_ISR;
        uswf_pkg::ADDR_DLL:   next_rdata = uswf_pkg::RST_DLL;
        default:              next_rdata = uswf_pkg::RST_ZERO;
      endcase
      if (addr == uswf_pkg::ADDR_XSTAT) begin
        next_xstat = uswf_pkg::RST_ZERO;
      end
    end
    if (ctl_done) begin
      next_xstat[XS_TX_RES]  = !send_stop;
      next_xstat[XS_TX_STOP] = send_stop;
    end
    if (rx_char_valid && rx_is_res) begin
      next_xstat[XS_RX_RES]  = 1'b1;
      next_xstat[XS_RX_STOP] = 1'b0;
    end else if (rx_char_valid && rx_is_stop) begin
      next_xstat[XS_RX_STOP] = 1'b1;
      next_xstat[XS_RX_RES]  = 1'b0;
    end
    if (next_efr[3:0] == 4'h0) begin
      next_xstat = uswf_pkg::RST_ZERO;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enhanced_feature_control          <= uswf_pkg::RST_ZERO;
      fsel         <= uswf_pkg::RST_ZERO;
      tx_fifo_trigger_level        <= uswf_pkg::RST_ZERO;
      rx_fifo_trigger_level        <= uswf_pkg::RST_ZERO;
      stop1        <= uswf_pkg::RST_ZERO;
      stop2        <= uswf_pkg::RST_ZERO;
      res1         <= uswf_pkg::RST_ZERO;
      res2         <= uswf_pkg::RST_ZERO;
      xstat        <= uswf_pkg::RST_ZERO;
      msr_lo       <= uswf_pkg::RST_ZERO;
      scratchpad_reg          <= uswf_pkg::RST_SPR;
      rdata        <= uswf_pkg::RST_ZERO;
      txfill       <= 9'h000;
      rxfill       <= 9'h000;
      halted       <= 1'b0;
      rx_stopped   <= 1'b0;
      pend_stop    <= 1'b0;
      pend_res     <= 1'b0;
      send_stop    <= 1'b0;
      tx_busy      <= 1'b0;
      rx_half      <= 1'b0;
      rx_half_stop <= 1'b0;
      st           <= uswf_pkg::USWF_TX_IDLE;
      ser_valid    <= 1'b0;
      ser_data     <= uswf_pkg::RST_ZERO;
      rx_fifo_push <= 1'b0;
      rx_fifo_data <= uswf_pkg::RST_ZERO;
      tx_irq       <= 1'b0;
      rx_irq       <= 1'b0;
      dir_tx       <= 1'b0;
      tx_halted    <= 1'b0;
    end else begin
      enhanced_feature_control          <= next_efr;
      fsel         <= next_fsel;
      tx_fifo_trigger_level        <= next_tx_fifo_trigger_level;
      rx_fifo_trigger_level        <= next_rx_fifo_trigger_level;
      stop1        <= next_stop1;
      stop2        <= next_stop2;
      res1         <= next_res1;
      res2         <= next_res2;
      xstat        <= next_xstat;
      msr_lo       <= next_msr_lo;
      scratchpad_reg          <= next_spr;
      rdata        <= next_rdata;
      txfill       <= next_txfill;
      rxfill       <= next_rxfill;
      halted       <= next_halted;
      rx_stopped   <= next_rx_stopped;
      pend_stop    <= next_pend_stop;
      pend_res     <= next_pend_res;
      send_stop    <= next_send_stop;
      tx_busy      <= next_tx_busy;
      rx_half      <= next_rx_half;
      rx_half_stop <= next_rx_half_stop;
      st           <= next_st;
      ser_valid    <= ser_valid_n;
      ser_data     <= ser_data_n;
      rx_fifo_push <= rxp_n;
      rx_fifo_data <= rxd_n;
      // A zero trigger never raises the transmit interrupt since nothing is below zero.
      tx_irq       <= (next_txfill < {1'b0, next_tx_fifo_trigger_level});
      rx_irq       <= (next_rx_fifo_trigger_level != 8'h00) && (next_rxfill >= {1'b0, next_rx_fifo_trigger_level});
      dir_tx       <= dir_n;
      tx_halted    <= next_halted;
    end
  end
endmodule : uswf_top

// >>> rtl/uswf_pkg.sv
// Package with register offsets, field positions and reset values for the flow control block.
package uswf_pkg;
  localparam logic [3:0] ADDR_EFR     = 4'h0;
  localparam logic [3:0] ADDR_FSEL    = 4'h1;
  localparam logic [3:0] ADDR_TX_FIFO_LEVEL_COUNT   = 4'h2;
  localparam logic [3:0] ADDR_TX_FIFO_TRIGGER_LEVEL   = 4'h3;
  localparam logic [3:0] ADDR_RX_FIFO_LEVEL_COUNT   = 4'h4;
  localparam logic [3:0] ADDR_RX_FIFO_TRIGGER_LEVEL   = 4'h5;
  localparam logic [3:0] ADDR_STOP1   = 4'h6;
  localparam logic [3:0] ADDR_STOP2   = 4'h7;
  localparam logic [3:0] ADDR_RES1    = 4'h8;
  localparam logic [3:0] ADDR_RES2    = 4'h9;
  localparam logic [3:0] ADDR_XSTAT   = 4'ha;
  localparam logic [3:0] ADDR_MSR     = 4'hb;
  localparam logic [3:0] ADDR_SPR     = 4'hc;
  localparam logic [3:0] ADDR_LSR     = 4'hd;
  localparam logic [3:0] ADDR_ISR     = 4'he;
  localparam logic [3:0] ADDR_DLL     = 4'hf;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_DLL      = 8'h01;
  localparam logic [7:0] RST_ISR      = 8'h01;
  localparam logic [7:0] RST_LSR      = 8'h60;
  localparam logic [7:0] RST_SPR      = 8'hff;
  localparam logic [8:0] FIFO_DEPTH   = 9'h100;
  localparam logic [7:0] CNT_MAX      = 8'hff;
  localparam int         FSEL_HDX_BIT = 5;
  localparam int         XS_TX_RES    = 3;
  localparam int         XS_TX_STOP   = 2;
  localparam int         XS_RX_RES    = 1;
  localparam int         XS_RX_STOP   = 0;
  localparam logic [1:0] SEL_NONE     = 2'b00;
  localparam logic [1:0] SEL_FIRST    = 2'b10;
  localparam logic [1:0] SEL_SECOND   = 2'b01;
  localparam logic [1:0] SEL_BOTH     = 2'b11;
  typedef enum logic [2:0] {USWF_TX_IDLE, USWF_TX_C1, USWF_TX_C2, USWF_TX_DATA} uswf_tx_state_t;
endpackage : uswf_pkg

// >>> testbench/uswf_chk.sv
// Assertion checker for the flow control block ports.
`timescale 1ns/1ps
module uswf_chk (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [3:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic       ser_ready,
  input wire logic       ser_valid,
  input wire logic [7:0] ser_data,
  input wire logic       rx_fifo_push,
  input wire logic [7:0] rx_fifo_data,
  input wire logic       dir_tx,
  input wire logic       tx_halted
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence offer_s;
    ser_valid && !ser_ready;
  endsequence
  sequence take_s;
    ser_valid && ser_ready;
  endsequence
  idle_read_a: assert property (!rd |=> rdata == 8'h00) else $error("read data not zero");
  line_stat_a: assert property (rd && addr == uswf_pkg::ADDR_LSR |=> rdata == uswf_pkg::RST_LSR)
    else $error("line status wrong");
  int_stat_a: assert property (rd && addr == uswf_pkg::ADDR_ISR |=> rdata == uswf_pkg::RST_ISR)
    else $error("interrupt status wrong");
  div_low_a: assert property (rd && addr == uswf_pkg::ADDR_DLL |=> rdata == uswf_pkg::RST_DLL)
    else $error("divisor low wrong");
  stat_resv_a: assert property (rd && addr == uswf_pkg::ADDR_XSTAT |=> rdata[7:4] == 4'h0)
    else $error("reserved status bits set");
  push_echo_a: assert property (rx_fifo_push |-> $past(rx_char_valid) && rx_fifo_data == $past(rx_char))
    else $error("fifo push not from a received character");
  ser_hold_a: assert property (offer_s |=> ser_valid && $stable(ser_data))
    else $error("offered character dropped or changed");
  ser_drop_a: assert property (take_s |=> !ser_valid) else $error("valid held after acceptance");
  reset_quiet_a: assert property ($rose(rstn) |-> !ser_valid && !rx_fifo_push && !dir_tx && !tx_halted)
    else $error("output active after reset");
  // The halt flag may only move in answer to a received character or a register write.
  halt_cause_a: assert property ($changed(tx_halted) |-> $past(rx_char_valid) || $past(rx_char_valid, 2)
    || $past(wr) || $past(wr, 2)) else $error("halt changed without cause");
endmodule : uswf_chk

bind uswf_top uswf_chk uswf_chk_i (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
  .rx_char_valid(rx_char_valid), .rx_char(rx_char), .ser_ready(ser_ready), .ser_valid(ser_valid),
  .ser_data(ser_data), .rx_fifo_push(rx_fifo_push), .rx_fifo_data(rx_fifo_data), .dir_tx(dir_tx),
  .tx_halted(tx_halted));

// >>> testbench/uswf_peer.sv
// Model of the remote serial device on the far side of the line.
`timescale 1ns/1ps
module uswf_peer (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       stall,
  input  wire logic       fast,
  input  wire logic       ser_valid,
  input  wire logic [7:0] ser_data,
  output logic            ser_ready,
  output logic            rx_char_valid,
  output logic      [7:0] rx_char
);
  logic [7:0] got[$];
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 8'h5a;
  end
  // In slow mode ready comes every other cycle, so held offers are exercised.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ser_ready <= 1'b0;
    end else begin
      if (ser_valid && ser_ready) begin
        got.push_back(ser_data);
      end
      ser_ready <= !stall && (fast || !ser_ready);
    end
  end
  // Between characters the line carries the inverse of the last one, never a stale copy.
  task automatic send(input logic [7:0] c);
    @(posedge core_clk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge core_clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
  endtask : send
endmodule : uswf_peer

// >>> testbench/tb_top.sv
// Self-checking testbench for the flow control block.
`timescale 1ns/1ps
module tb_top;
  logic       core_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, ser_data, rx_char, rx_fifo_data;
  logic       host_tx_push = 1'b0, host_rx_pop = 1'b0, stall = 1'b1, fast = 1'b0;
  logic       rx_char_valid, ser_ready, ser_valid, rx_fifo_push, tx_irq, rx_irq, dir_tx, tx_halted;
  int         mismatches = 0, checked = 0, pushes = 0, p0;
  logic [3:0] ra[10] = '{uswf_pkg::ADDR_EFR, uswf_pkg::ADDR_FSEL, uswf_pkg::ADDR_TX_FIFO_LEVEL_COUNT, uswf_pkg::ADDR_RX_FIFO_LEVEL_COUNT,
    uswf_pkg::ADDR_XSTAT, uswf_pkg::ADDR_SPR, uswf_pkg::ADDR_LSR, uswf_pkg::ADDR_ISR, uswf_pkg::ADDR_DLL,
    uswf_pkg::ADDR_MSR};
  logic [7:0] rv[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h60, 8'h01, 8'h01, 8'ha0};
  logic [7:0] ch[4] = '{8'h13, 8'h93, 8'h11, 8'h91};
  logic [7:0] md[6] = '{8'h02, 8'h01, 8'h0b, 8'h07, 8'h0f, 8'h03};
  int         wm[6] = '{0, 1, 1, 0, 2, 2};
  logic [7:0] tm[3] = '{8'h08, 8'h04, 8'h0c};

  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (rx_fifo_push === 1'b1) pushes++;

  uswf_top uswf_top_i (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .host_tx_push(host_tx_push), .host_tx_data(8'h41), .host_rx_pop(host_rx_pop),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .modem_in(4'ha), .ser_ready(ser_ready),
    .ser_valid(ser_valid), .ser_data(ser_data), .rx_fifo_push(rx_fifo_push), .rx_fifo_data(rx_fifo_data),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .dir_tx(dir_tx), .tx_halted(tx_halted));
  uswf_peer uswf_peer_i (.core_clk(core_clk), .rstn(rstn), .stall(stall), .fast(fast), .ser_valid(ser_valid),
    .ser_data(ser_data), .ser_ready(ser_ready), .rx_char_valid(rx_char_valid), .rx_char(rx_char));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rchk
  task automatic push_tx(input int n);
    @(posedge core_clk);
    host_tx_push <= 1'b1;
    repeat (n) @(posedge core_clk);
    host_tx_push <= 1'b0;
  endtask : push_tx
  task automatic pop_rx();
    @(posedge core_clk);
    host_rx_pop <= 1'b1;
    @(posedge core_clk);
    host_rx_pop <= 1'b0;
  endtask : pop_rx
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic ctl(input logic [7:0] f, input logic [7:0] s, input int w);
    if (w != 1) uswf_peer_i.send(f);
    if (w != 0) uswf_peer_i.send(s);
  endtask : ctl
  // Waits for the expected control characters on the line, then compares them in order.
  task automatic expc(input logic [7:0] f, input logic [7:0] s, input int w);
    int n;
    int k;
    n = (w == 2) ? 2 : 1;
    for (k = 0; k < 2000 && uswf_peer_i.got.size() < n; k++) @(posedge core_clk);
    chk(8'(uswf_peer_i.got.size()), 8'(n));
    if (w == 2) begin
      chk(uswf_peer_i.got[0], f);
      chk(uswf_peer_i.got[1], s);
    end else begin
      chk(uswf_peer_i.got[0], (w == 0) ? f : s);
    end
    uswf_peer_i.got.delete();
  endtask : expc
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (ra[i]) rchk(ra[i], rv[i]);
    wr_reg(uswf_pkg::ADDR_TX_FIFO_LEVEL_COUNT, 8'h55);
    rchk(uswf_pkg::ADDR_TX_FIFO_LEVEL_COUNT, 8'h00);
    push_tx(3);
    rchk(uswf_pkg::ADDR_TX_FIFO_LEVEL_COUNT, 8'h03);
    wr_reg(uswf_pkg::ADDR_TX_FIFO_TRIGGER_LEVEL, 8'h04);
    settle();
    chk({7'h00, tx_irq}, 8'h01);
    wr_reg(uswf_pkg::ADDR_TX_FIFO_TRIGGER_LEVEL, 8'h03);
    settle();
    chk({7'h00, tx_irq}, 8'h00);
    push_tx(252);
    rchk(uswf_pkg::ADDR_TX_FIFO_LEVEL_COUNT, 8'hff);
    push_tx(1);
    rchk(uswf_pkg::ADDR_TX_FIFO_LEVEL_COUNT, 8'hff);
    wr_reg(uswf_pkg::ADDR_FSEL, 8'h20);
    settle();
    chk({7'h00, dir_tx}, 8'h01);
    stall <= 1'b0;
    for (int k = 0; k < 3000 && uswf_peer_i.got.size() < 256; k++) @(posedge core_clk);
    settle();
    foreach (uswf_peer_i.got[i]) chk(uswf_peer_i.got[i], 8'h41);
    chk(8'(uswf_peer_i.got.size() - 1), 8'hff);
    rchk(uswf_pkg::ADDR_TX_FIFO_LEVEL_COUNT, 8'h00);
    chk({6'h00, dir_tx, tx_irq}, 8'h01);
    wr_reg(uswf_pkg::ADDR_FSEL, 8'h00);
    uswf_peer_i.got.delete();
    wr_reg(uswf_pkg::ADDR_RX_FIFO_TRIGGER_LEVEL, 8'h02);
    ctl(8'h30, 8'h31, 2);
    settle();
    rchk(uswf_pkg::ADDR_RX_FIFO_LEVEL_COUNT, 8'h02);
    chk({rx_irq, 7'(pushes)}, 8'h82);
    pop_rx();
    settle();
    chk({7'h00, rx_irq}, 8'h00);
    pop_rx();
    for (int i = 0; i < 4; i++) wr_reg(uswf_pkg::ADDR_STOP1 + 4'(i), ch[i]);
    foreach (md[m]) begin
      wr_reg(uswf_pkg::ADDR_EFR, 8'h00);
      wr_reg(uswf_pkg::ADDR_EFR, md[m]);
      p0 = pushes;
      ctl(ch[0], ch[1], wm[m]);
      settle();
      chk({7'h00, tx_halted}, 8'h01);
      rchk(uswf_pkg::ADDR_XSTAT, 8'h01);
      rchk(uswf_pkg::ADDR_XSTAT, 8'h00);
      ctl(ch[2], ch[3], wm[m]);
      settle();
      chk({7'h00, tx_halted}, 8'h00);
      rchk(uswf_pkg::ADDR_XSTAT, 8'h02);
      chk(8'(pushes - p0), 8'h00);
    end
    ctl(ch[0], 8'h41, 2);
    settle();
    chk({7'h00, tx_halted}, 8'h00);
    ctl(ch[0], ch[1], 2);
    ctl(ch[2], ch[3], 2);
    wr_reg(uswf_pkg::ADDR_EFR, 8'h00);
    rchk(uswf_pkg::ADDR_XSTAT, 8'h00);
    pop_rx();
    fast <= 1'b1;
    uswf_peer_i.got.delete();
    foreach (tm[m]) begin
      wr_reg(uswf_pkg::ADDR_EFR, 8'h00);
      wr_reg(uswf_pkg::ADDR_EFR, tm[m]);
      ctl(8'h30, 8'h31, 2);
      expc(ch[0], ch[1], m);
      rchk(uswf_pkg::ADDR_XSTAT, 8'h04);
      pop_rx();
      expc(ch[2], ch[3], m);
      rchk(uswf_pkg::ADDR_XSTAT, 8'h08);
      pop_rx();
    end
    tally_and_finish();
  end
endmodule : tb_top
